// [verilog/rst_boot_pkg.sv]
// Package with shared constants and carriers for reset and boot-mode capture.
package rst_boot_pkg;

  // Number of boot-select pins and modes.
  localparam int unsigned MODE_PINS = 3;
  localparam int unsigned MODE_COUNT = 8;

  // Synchroniser depth and internal reset stretch after release.
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned STRETCH_CYCLES = 4;
  localparam logic [2:0] STRETCH_LAST = 3'(STRETCH_CYCLES - 1);

  // Bootstrap length in cycles after the internal reset ends.
  localparam int unsigned BOOT_CYCLES = 16;
  localparam logic [4:0] BOOT_LAST = 5'(BOOT_CYCLES - 1);

  // Reset values of the captured mode and the one-hot decode.
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [7:0] ONEHOT_RESET = 8'h00;

  // Phases of the sequencer.
  typedef enum logic [1:0] {
    PH_RESET,
    PH_STRETCH,
    PH_BOOT,
    PH_RUN
  } phase_t;

  // Reset source levels gathered together.
  typedef struct packed {
    logic ext_rst;
    logic low_voltage;
    logic sw_reset;
    logic watchdog_timeout;
  } rst_src_t;

  // Direction and drive of one port H pin group.
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } pin_drive_t;

endpackage

// [verilog/rst_sync.sv]
// Two-flop reset release synchroniser.
`timescale 1ns/10ps
module rst_sync #(
  parameter int unsigned STAGES = 2
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  output logic      rst_sync_n
);

  logic [STAGES-1:0] chain_ff;

  // Assertion is asynchronous; release ripples through the chain.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chain_ff <= '0;
    end else begin
      chain_ff <= {chain_ff[STAGES-2:0], 1'b1};
    end
  end

  assign rst_sync_n = chain_ff[STAGES-1];

endmodule

// [verilog/reset_boot_mode_capture.sv]
// Reset sequencer with boot-mode capture and port H pin release.
`timescale 1ns/10ps
module reset_boot_mode_capture #(
  parameter int unsigned BOOT_LEN = rst_boot_pkg::BOOT_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       low_voltage,
  input  wire logic       sw_reset,
  input  wire logic       watchdog_timeout,
  input  wire logic       port_h_pin0_io_in,
  input  wire logic       port_h_pin1_io_in,
  input  wire logic       port_h_pin2_io_in,
  input  wire logic [2:0] gpio_out,
  input  wire logic [2:0] gpio_oe,
  output logic            port_h_pin0_io_out,
  output logic            port_h_pin1_io_out,
  output logic            port_h_pin2_io_out,
  output logic            port_h_pin0_io_oe,
  output logic            port_h_pin1_io_oe,
  output logic            port_h_pin2_io_oe,
  output logic [2:0]      gpio_in,
  output logic            reset_out_pin_n,
  output logic            core_rst_n,
  output logic            boot_active,
  output logic [2:0]      boot_mode,
  output logic [7:0]      boot_mode_onehot
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Decodes a three-bit mode into a one-hot word of eight.
  function automatic logic [7:0] decode_mode(input logic [2:0] m);
    logic [7:0] r;
    r = 8'h01 << m;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reset sources and synchronised release
  // ----------------------------------------------------------------

  logic                    ext_rst_sync_n;
  rst_boot_pkg::rst_src_t  src;
  logic                    any_src;
  logic [2:0]              pins_in;

  // Release of the external reset is retimed to mclk.
  rst_sync #(
    .STAGES (rst_boot_pkg::SYNC_STAGES)
  ) u_sync (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .rst_sync_n (ext_rst_sync_n)
  );

  // Gathers every reset condition into one level.
  assign src.ext_rst          = ~ext_rst_sync_n;
  assign src.low_voltage      = low_voltage;
  assign src.sw_reset         = sw_reset;
  assign src.watchdog_timeout = watchdog_timeout;
  assign any_src              = |src;
  assign pins_in = {port_h_pin2_io_in, port_h_pin1_io_in, port_h_pin0_io_in};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------

  rst_boot_pkg::phase_t phase_ff;
  rst_boot_pkg::phase_t nxt_phase;
  logic [2:0]           stretch_ff;
  logic [4:0]           boot_cnt_ff;
  logic [4:0]           boot_last;

  assign boot_last = 5'(BOOT_LEN - 1);

  // Picks the next phase; any reset source returns to the reset phase.
  always_comb begin
    nxt_phase = phase_ff;
    if (any_src) begin
      nxt_phase = rst_boot_pkg::PH_RESET;
    end else begin
      case (phase_ff)
        rst_boot_pkg::PH_RESET: begin
          nxt_phase = rst_boot_pkg::PH_STRETCH;
        end
        rst_boot_pkg::PH_STRETCH: begin
          if (stretch_ff == rst_boot_pkg::STRETCH_LAST) begin
            nxt_phase = rst_boot_pkg::PH_BOOT;
          end
        end
        rst_boot_pkg::PH_BOOT: begin
          if (boot_cnt_ff == boot_last) begin
            nxt_phase = rst_boot_pkg::PH_RUN;
          end
        end
        rst_boot_pkg::PH_RUN: begin
          nxt_phase = rst_boot_pkg::PH_RUN;
        end
        default: begin
          nxt_phase = rst_boot_pkg::PH_RESET;
        end
      endcase
    end
  end

  // Holds the phase.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= rst_boot_pkg::PH_RESET;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Counts the stretch cycles after release.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stretch_ff <= 3'h0;
    end else if (phase_ff == rst_boot_pkg::PH_STRETCH && !any_src) begin
      stretch_ff <= stretch_ff + 3'h1;
    end else begin
      stretch_ff <= 3'h0;
    end
  end

  // Counts the bootstrap cycles.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_ff <= 5'h00;
    end else if (phase_ff == rst_boot_pkg::PH_BOOT && !any_src) begin
      boot_cnt_ff <= boot_cnt_ff + 5'h01;
    end else begin
      boot_cnt_ff <= 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Boot mode capture
  // ----------------------------------------------------------------

  logic [2:0] mode_ff;
  logic [7:0] onehot_ff;

  // Latches the pins on the first cycle after all reset sources end.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= rst_boot_pkg::MODE_RESET;
    end else if (phase_ff == rst_boot_pkg::PH_RESET && !any_src) begin
      mode_ff <= pins_in;
    end
  end

  // Keeps the one-hot decode of the captured mode.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      onehot_ff <= rst_boot_pkg::ONEHOT_RESET;
    end else if (phase_ff == rst_boot_pkg::PH_RESET) begin
      onehot_ff <= rst_boot_pkg::ONEHOT_RESET;
    end else begin
      onehot_ff <= decode_mode(mode_ff);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Reset output and internal reset, both registered.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_out_pin_n <= 1'b0;
      core_rst_n      <= 1'b0;
    end else begin
      reset_out_pin_n <= ~any_src;
      core_rst_n      <= (nxt_phase == rst_boot_pkg::PH_BOOT) || (nxt_phase == rst_boot_pkg::PH_RUN);
    end
  end

  // Boot status outputs.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boot_active      <= 1'b0;
      boot_mode        <= rst_boot_pkg::MODE_RESET;
      boot_mode_onehot <= rst_boot_pkg::ONEHOT_RESET;
    end else begin
      boot_active      <= (nxt_phase == rst_boot_pkg::PH_BOOT);
      boot_mode        <= mode_ff;
      boot_mode_onehot <= onehot_ff;
    end
  end

  // Port H pins stay inputs until bootstrap is over, then follow GPIO.
  rst_boot_pkg::pin_drive_t drv;
  logic                     run_next;

  assign run_next = (nxt_phase == rst_boot_pkg::PH_RUN);
  assign drv.out  = run_next ? gpio_out : 3'h0;
  assign drv.oe   = run_next ? gpio_oe : 3'h0;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_h_pin0_io_out <= 1'b0;
      port_h_pin1_io_out <= 1'b0;
      port_h_pin2_io_out <= 1'b0;
      port_h_pin0_io_oe  <= 1'b0;
      port_h_pin1_io_oe  <= 1'b0;
      port_h_pin2_io_oe  <= 1'b0;
      gpio_in            <= 3'h0;
    end else begin
      port_h_pin0_io_out <= drv.out[0];
      port_h_pin1_io_out <= drv.out[1];
      port_h_pin2_io_out <= drv.out[2];
      port_h_pin0_io_oe  <= drv.oe[0];
      port_h_pin1_io_oe  <= drv.oe[1];
      port_h_pin2_io_oe  <= drv.oe[2];
      gpio_in            <= run_next ? pins_in : 3'h0;
    end
  end

endmodule

// [tb/board_reset_model.sv]
// Board reset circuitry, debugger test reset and boot-select straps.
`timescale 1ns/10ps
module board_reset_model (
  input  wire logic       full_rst,
  input  wire logic       dbg_rst,
  input  wire logic [2:0] strap,
  output logic            arst_n,
  output logic            trst_n,
  output logic [2:0]      pin
);
  // Chip reset falls for both requests; the test reset only for a full one.
  assign arst_n = !(full_rst || dbg_rst);
  assign trst_n = !full_rst;
  // Straps and board logic drive the port H pins at all times.
  assign pin = strap;
endmodule

// [tb/rbm_checker.sv]
// Checker bound to the reset and boot-mode capture block.
`timescale 1ns/10ps
module rbm_checker (
  input wire logic       mclk,
  input wire logic       arst_n,
  input wire logic       low_voltage,
  input wire logic       sw_reset,
  input wire logic       watchdog_timeout,
  input wire logic       port_h_pin0_io_in,
  input wire logic       port_h_pin1_io_in,
  input wire logic       port_h_pin2_io_in,
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe,
  input wire logic       port_h_pin0_io_out,
  input wire logic       port_h_pin1_io_out,
  input wire logic       port_h_pin2_io_out,
  input wire logic       port_h_pin0_io_oe,
  input wire logic       port_h_pin1_io_oe,
  input wire logic       port_h_pin2_io_oe,
  input wire logic [2:0] gpio_in,
  input wire logic       reset_out_pin_n,
  input wire logic       core_rst_n,
  input wire logic       boot_active,
  input wire logic [2:0] boot_mode,
  input wire logic [7:0] boot_mode_onehot
);
  // Grouped views of the sources and the pins.
  wire       src  = low_voltage | sw_reset | watchdog_timeout;
  wire [2:0] pins = {port_h_pin2_io_in, port_h_pin1_io_in, port_h_pin0_io_in};
  wire [2:0] oe   = {port_h_pin2_io_oe, port_h_pin1_io_oe, port_h_pin0_io_oe};
  wire [2:0] out  = {port_h_pin2_io_out, port_h_pin1_io_out, port_h_pin0_io_out};
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_hold_in_reset: assert property (disable iff (1'b0) !arst_n |->
    !core_rst_n && !reset_out_pin_n && !boot_active && oe == 3'h0) else $error("outputs active in reset");
  a_source_reset: assert property (src |=> !reset_out_pin_n ##1 !core_rst_n)
    else $error("source did not reset");
  a_sync_stretch: assert property ($rose(core_rst_n) |-> $past(reset_out_pin_n, 4) && boot_active)
    else $error("internal reset ended early");
  a_mode_capture: assert property ($rose(reset_out_pin_n) |=> boot_mode == $past(pins, 2))
    else $error("boot mode not captured");
  a_mode_decode: assert property (core_rst_n |-> boot_mode_onehot == 8'h01 << boot_mode)
    else $error("boot mode decode wrong");
  a_pins_held: assert property (boot_active |-> oe == 3'h0 && gpio_in == 3'h0)
    else $error("pins released during boot");
  a_gpio_release: assert property (core_rst_n && !boot_active && $past(core_rst_n && !boot_active)
    && !$past(src) |-> oe == $past(gpio_oe) && out == $past(gpio_out) && gpio_in == $past(pins))
    else $error("pins not released to port");
endmodule
bind reset_boot_mode_capture rbm_checker i_rbm_checker (.mclk, .arst_n, .low_voltage, .sw_reset,
  .watchdog_timeout, .port_h_pin0_io_in, .port_h_pin1_io_in, .port_h_pin2_io_in, .gpio_out, .gpio_oe,
  .port_h_pin0_io_out, .port_h_pin1_io_out, .port_h_pin2_io_out, .port_h_pin0_io_oe, .port_h_pin1_io_oe,
  .port_h_pin2_io_oe, .gpio_in, .reset_out_pin_n, .core_rst_n, .boot_active, .boot_mode, .boot_mode_onehot);

// [tb/tb.sv]
// Testbench for reset sequencing, boot-mode capture and port H release.
`timescale 1ns/10ps
module tb;
  logic       mclk, arst_n, trst_n, full_rst, dbg_rst, low_voltage, sw_reset, watchdog_timeout;
  logic [2:0] strap, pin, gpio_out, gpio_oe, gpio_in, out, oe, boot_mode;
  logic [7:0] boot_mode_onehot;
  logic       reset_out_pin_n, core_rst_n, boot_active;
  int         failures, checks_done;
  board_reset_model i_board_reset_model (.full_rst(full_rst), .dbg_rst(dbg_rst), .strap(strap),
    .arst_n(arst_n), .trst_n(trst_n), .pin(pin));
  reset_boot_mode_capture #(.BOOT_LEN(2)) i_reset_boot_mode_capture (.mclk(mclk), .arst_n(arst_n),
    .low_voltage(low_voltage), .sw_reset(sw_reset), .watchdog_timeout(watchdog_timeout),
    .port_h_pin0_io_in(pin[0]), .port_h_pin1_io_in(pin[1]), .port_h_pin2_io_in(pin[2]),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .port_h_pin0_io_out(out[0]), .port_h_pin1_io_out(out[1]),
    .port_h_pin2_io_out(out[2]), .port_h_pin0_io_oe(oe[0]), .port_h_pin1_io_oe(oe[1]),
    .port_h_pin2_io_oe(oe[2]), .gpio_in(gpio_in), .reset_out_pin_n(reset_out_pin_n),
    .core_rst_n(core_rst_n), .boot_active(boot_active), .boot_mode(boot_mode),
    .boot_mode_onehot(boot_mode_onehot));
  // Clock at 25 MHz.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Compares one value and counts the outcome.
  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Moves to just after the n-th next rising edge.
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  // Boots every mode, alternating full and debugger resets.
  task boot_modes;
    for (int m = 0; m < 8; m++) begin
      strap = m[2:0];
      full_rst = m[0];
      dbg_rst = !m[0];
      tick(3);
      chk({core_rst_n, reset_out_pin_n, boot_active}, 8'h00, "held in reset");
      chk({arst_n, trst_n}, {7'h00, !m[0]}, "test reset follows full reset only");
      full_rst = 1'b0;
      dbg_rst = 1'b0;
      tick(6);
      strap = ~m[2:0];
      chk(core_rst_n, 8'h00, "internal reset ended early");
      tick(1);
      chk({core_rst_n, boot_active, oe}, 8'h18, "bootstrap start");
      chk(boot_mode, m[2:0], "mode capture");
      chk(boot_mode_onehot, 8'(1 << m), "mode decode");
    end
  endtask
  // After bootstrap the pins follow the port controller, and keep following it.
  task run_gpio;
    gpio_out = 3'h5;
    gpio_oe = 3'h3;
    strap = 3'h6;
    tick(2);
    chk({boot_active, oe, out}, 8'h1D, "pins released");
    chk(gpio_in, 8'h06, "port input");
    gpio_out = 3'h2;
    gpio_oe = 3'h4;
    strap = 3'h1;
    tick(2);
    chk({boot_active, oe, out}, 8'h22, "pins follow port");
    chk(gpio_in, 8'h01, "port input follows pins");
    chk(boot_mode, 8'h07, "mode kept in run");
  endtask
  // Low-voltage, software and watchdog resets each reset the core and recapture the mode.
  task sources;
    for (int s = 0; s < 3; s++) begin
      strap = 3'(s + 2);
      {low_voltage, sw_reset, watchdog_timeout} = 3'(4 >> s);
      tick(2);
      chk({reset_out_pin_n, core_rst_n, oe}, 8'h00, "source reset");
      {low_voltage, sw_reset, watchdog_timeout} = 3'h0;
      for (int i = 0; i < 20; i++) if (core_rst_n !== 1'b1) tick(1);
      chk({reset_out_pin_n, core_rst_n, boot_mode}, 8'(s + 26), "recapture");
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task give_verdict;
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {full_rst, dbg_rst, low_voltage, sw_reset, watchdog_timeout} = 5'h10;
    {strap, gpio_out, gpio_oe} = 9'h000;
    failures = 0;
    checks_done = 0;
    tick(12);
    boot_modes;
    run_gpio;
    sources;
    give_verdict;
  end
  // Cuts a hang short.
  initial begin
    #100000;
    failures++;
    give_verdict;
  end
endmodule
